// ### drp_ctrl.sv
// drp_ctrl: apb register file for dac range, reference and power-down.
// assumes apb3 master on pclk; convert pin synchronous to pclk.
//
// Functional notes
// R1: dac gain is one when its select bit is 0, two when 1.
// R2: internal reference level bit picks 1.25 v at 0, 2.5 v at 1.
// R3: source select 0 connects internal reference to pin; 1 disconnects it.
// R4: reset clears dac data, dac latches, gain and reference select bits.
// R5: power register holds enables for adc, each dac, amplifier, ref buffer.
// R6: after any reset the power register is zero, all units powered down.
// R7: powered-down adc stops converting; powered-down dac output goes to ground.
// R8: internal reference and oscillator stay powered regardless of power bits.
// R9: power settings never affect digital logic such as the bus.
// R10: writes during power-down are stored but start nothing, change no output.
// R11: stored values take effect at once when the unit leaves power-down.
// R12: configuration registers keep contents across power-down entry and exit.
// R13: adc results and alarms survive power-down only in direct mode.
// R14: host should not issue a convert while the adc is powered down.
// R15: general-purpose i/o data are unaffected by power-down.
// R16: clearing one dac power bit powers down that dac alone.
// R17: host sets source select whenever an external reference is applied.
// R18: power bits read back as written; reset clears them asynchronously.
`timescale 1ns/1ps
module drp_ctrl
    import drp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convert_pin,
    input wire logic external_dac_load,
    output logic adc_start,
    output logic adc_results_clear,
    output logic [NUM_DAC-1:0][DAC_W-1:0] dac_code,
    output drp_analog_t analog
);

    ////////////////////////////////////////////////////////////////////
    // bus decode

    logic setup_phase;
    logic wr_access;
    logic addr_mapped;
    logic addr_is_dac;
    logic [2:0] dac_index;
    logic [31:0] read_value;

    logic [CFG_W-1:0] cfg_reg;
    logic [PWR_W-1:0] pwr_reg;
    logic soft_reset_reg;
    logic convert_pin_reg;
    logic keep_results_reg;
    logic results_cleared_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [NUM_DAC-1:0][DAC_W-1:0] dac_input;
    logic [NUM_DAC-1:0] dac_wr;
    logic convert_req;
    logic adc_pd_entry;
    logic [ADDR_W-1:0] dac_offset;
    logic [NUM_DAC-1:0] chan_gain_two;
    logic [NUM_DAC-1:0] chan_buffer_on;
    logic [NUM_DAC-1:0] chan_ground_switch;
    logic ref_connect;
    logic ref_level_high;
    logic ref_on;

    assign setup_phase = psel && !penable;
    // zero-wait slave; pready never depends on the power register
    assign pready = 1'b1; // R9
    assign wr_access = psel && penable && pwrite && !pslverr_reg;
    assign addr_is_dac = (paddr >= OFF_DAC_BASE) && (paddr <= OFF_DAC_LAST)
        && (paddr[1:0] == 2'b00);
    // channel n sits at base + 4n; raw address bits would rotate the map
    assign dac_offset = paddr - OFF_DAC_BASE;
    assign dac_index = dac_offset[4:2];
    assign addr_mapped = addr_is_dac || paddr == OFF_CONFIG
        || paddr == OFF_POWER || paddr == OFF_STATUS
        || paddr == OFF_CONTROL;

    always_comb begin
        read_value = 32'h0000_0000;
        if (addr_is_dac) begin
            // reads return the latch, which is what drives the output
            read_value[DAC_W-1:0] = dac_code[dac_index];
        end else if (paddr == OFF_CONFIG) begin
            read_value[CFG_W-1:0] = cfg_reg;
        end else if (paddr == OFF_POWER) begin
            read_value[PWR_W-1:0] = pwr_reg; // R18
        end else if (paddr == OFF_STATUS) begin
            read_value[STS_ADC_ON_BIT] = pwr_reg[PWR_ADC_BIT];
            read_value[STS_REF_CONN_BIT] = analog.reference_pin_connect;
            read_value[STS_LVL_HIGH_BIT] = analog.reference_level_high;
            read_value[STS_KEEP_BIT] = keep_results_reg;
            read_value[STS_CLEARED_BIT] = results_cleared_reg;
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
            pslverr_reg <= !addr_mapped;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = psel && penable && pslverr_reg;

    ////////////////////////////////////////////////////////////////////
    // configuration and power registers

    // power-down never touches this register, so settings survive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RST; // R4
        end else if (soft_reset_reg) begin
            cfg_reg <= CFG_RST; // R4
        end else if (wr_access && paddr == OFF_CONFIG) begin
            cfg_reg <= pwdata[CFG_W-1:0]; // R12
        end
    end

    // cleared means powered down: every unit with a power bit starts off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= PWR_RST; // R6 R18
        end else if (soft_reset_reg) begin
            pwr_reg <= PWR_RST; // R6
        end else if (wr_access && paddr == OFF_POWER) begin
            pwr_reg <= pwdata[PWR_W-1:0]; // R5 R18
        end
    end

    // software reset acts one cycle after the control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= wr_access && paddr == OFF_CONTROL
                && pwdata[CTL_SOFT_RESET_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // adc convert gating and result retention

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            convert_pin_reg <= 1'b0;
        end else begin
            convert_pin_reg <= convert_pin;
        end
    end

    assign convert_req = (convert_pin && !convert_pin_reg)
        || (wr_access && paddr == OFF_CONTROL && pwdata[CTL_CONVERT_BIT]);
    // a convert request while powered down is dropped, not queued
    assign adc_start = convert_req && pwr_reg[PWR_ADC_BIT]
        && !soft_reset_reg; // R7 R10 R14
    assign adc_pd_entry = wr_access && paddr == OFF_POWER
        && pwr_reg[PWR_ADC_BIT] && !pwdata[PWR_ADC_BIT];

    // results kept only when the adc went down in direct mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_results_reg <= 1'b0;
            results_cleared_reg <= 1'b0;
            adc_results_clear <= 1'b0;
        end else begin
            adc_results_clear <= adc_pd_entry
                && !cfg_reg[CFG_DIRECT_BIT]; // R13
            if (adc_pd_entry) begin
                keep_results_reg <= cfg_reg[CFG_DIRECT_BIT]; // R13
                results_cleared_reg <= !cfg_reg[CFG_DIRECT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dac channels and reference

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DAC; gi++) begin : g_dac
            assign dac_wr[gi] = wr_access && addr_is_dac
                && dac_index == 3'(gi);
            drp_dac_chan u_dac (
                .pclk(pclk),
                .presetn(presetn),
                .soft_reset(soft_reset_reg),
                .wr_en(dac_wr[gi]),
                .wr_data(pwdata[DAC_W-1:0]),
                .power_en(pwr_reg[PWR_DAC_LSB+gi]), // R16
                .gain_sel(cfg_reg[CFG_GAIN_LSB+gi]), // R1
                .code(dac_code[gi]),
                .input_value(dac_input[gi]),
                .buffer_on(chan_buffer_on[gi]),
                .ground_switch(chan_ground_switch[gi]),
                .gain_two(chan_gain_two[gi])
            );
        end
    endgenerate

    drp_ref_ctrl u_ref (
        .pclk(pclk),
        .presetn(presetn),
        .reference_source_select(cfg_reg[CFG_SRC_BIT]), // R17
        .internal_reference_level(cfg_reg[CFG_LVL_BIT]),
        .reference_pin_connect(ref_connect),
        .reference_level_high(ref_level_high),
        .internal_reference_on(ref_on)
    );

    // the load pin is left unconnected; each dac latch loads while its power bit is set
    // one driver for the whole carrier keeps every field single-sourced
    assign analog = '{
        dac_gain_two: chan_gain_two, // R1
        dac_buffer_on: chan_buffer_on, // R16
        dac_ground_switch: chan_ground_switch, // R7
        reference_pin_connect: ref_connect, // R3
        reference_level_high: ref_level_high, // R2
        internal_reference_on: ref_on, // R8
        oscillator_on: 1'b1, // R8
        adc_power_on: pwr_reg[PWR_ADC_BIT], // R5
        current_source_amp_on: pwr_reg[PWR_CS_BIT], // R5
        reference_buffer_on: pwr_reg[PWR_REFBUF_BIT] // R5
    };

    ////////////////////////////////////////////////////////////////////
    // checks

    a_convert_gated: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        adc_start |-> analog.adc_power_on
    ) else $error("adc started while powered down");

    a_soft_reset_clr: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        soft_reset_reg |=> (pwr_reg == PWR_RST && cfg_reg == CFG_RST
            && dac_code[0] == DAC_RST)
    ) else $error("software reset left state uncleared");

    a_power_readback: assert property ( // R18
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == OFF_POWER && !soft_reset_reg)
        |=> pwr_reg == $past(pwdata[PWR_W-1:0])
    ) else $error("power register did not store written value");

    a_cfg_survives_pd: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == OFF_POWER && !soft_reset_reg)
        |=> $stable(cfg_reg)
    ) else $error("configuration changed on power transition");

    a_results_keep: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        adc_pd_entry |=> (adc_results_clear != keep_results_reg)
    ) else $error("adc result retention wrong on power-down");

    a_dac_isolated: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        analog.dac_ground_switch == ~pwr_reg[PWR_DAC_LSB +: NUM_DAC]
    ) else $error("dac ground switch does not follow its own bit");

    a_bus_alive: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> pready
    ) else $error("bus stalled");

    a_gain_follow: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        analog.dac_gain_two == cfg_reg[CFG_GAIN_LSB +: NUM_DAC]
    ) else $error("dac gain select mismatch");

    a_data_kept_pd: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == OFF_POWER && !soft_reset_reg)
        |=> $stable(dac_input)
    ) else $error("stored dac data changed on power transition");

    a_status_flags: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        adc_pd_entry |=> (keep_results_reg == $past(cfg_reg[CFG_DIRECT_BIT])
            && results_cleared_reg != keep_results_reg)
    ) else $error("result retention flags wrong after power-down");

    a_unmapped_err: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> (pslverr == !addr_mapped)
    ) else $error("error response does not match address decode");

endmodule

// ### drp_pkg.sv
// drp_pkg: constants, register map and carrier types for the
// dac range / reference / power-down control block.
// assumes an apb slave with 32-bit data, one aligned word per register.
package drp_pkg;

    localparam int NUM_DAC = 8;
    localparam int DAC_W = 12;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_POWER = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_DAC_BASE = 8'h10;
    localparam logic [7:0] OFF_DAC_LAST = 8'h2c;

    // config register fields (gain bits sit at 7:0)
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_SRC_BIT = 8;
    localparam int CFG_LVL_BIT = 9;
    localparam int CFG_DIRECT_BIT = 10;
    localparam int CFG_W = 11;

    // power register fields (dac enables sit at 8:1)
    localparam int PWR_ADC_BIT = 0;
    localparam int PWR_DAC_LSB = 1;
    localparam int PWR_CS_BIT = 9;
    localparam int PWR_REFBUF_BIT = 10;
    localparam int PWR_W = 11;

    // control register fields (write-only strobes)
    localparam int CTL_CONVERT_BIT = 0;
    localparam int CTL_SOFT_RESET_BIT = 1;

    // status register fields
    localparam int STS_ADC_ON_BIT = 0;
    localparam int STS_REF_CONN_BIT = 1;
    localparam int STS_LVL_HIGH_BIT = 2;
    localparam int STS_KEEP_BIT = 3;
    localparam int STS_CLEARED_BIT = 4;

    // reset values
    localparam logic [CFG_W-1:0] CFG_RST = 11'h000;
    localparam logic [PWR_W-1:0] PWR_RST = 11'h000;
    localparam logic [DAC_W-1:0] DAC_RST = 12'h000;

    typedef struct packed {
        logic [NUM_DAC-1:0] dac_gain_two;
        logic [NUM_DAC-1:0] dac_buffer_on;
        logic [NUM_DAC-1:0] dac_ground_switch;
        logic reference_pin_connect;
        logic reference_level_high;
        logic internal_reference_on;
        logic oscillator_on;
        logic adc_power_on;
        logic current_source_amp_on;
        logic reference_buffer_on;
    } drp_analog_t;

endpackage

// ### drp_ref_ctrl.sv
// drp_ref_ctrl: internal reference connection and level selection.
// assumes the select bits come straight from registers in one clock domain.
`timescale 1ns/1ps
module drp_ref_ctrl
    import drp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reference_source_select,
    input wire logic internal_reference_level,
    output logic reference_pin_connect,
    output logic reference_level_high,
    output logic internal_reference_on
);

    // zero keeps the internal source on the pin; one leaves it external
    assign reference_pin_connect = ~reference_source_select; // R3
    // 0 picks 1.25 v, 1 picks 2.5 v
    assign reference_level_high = internal_reference_level; // R2
    // never gated by power-down, so wake-up needs no reference settling
    assign internal_reference_on = 1'b1; // R8

    ////////////////////////////////////////////////////////////////////
    a_ref_select: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        reference_source_select != reference_pin_connect
    ) else $error("reference pin connection does not follow source select");

    a_ref_always_on: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        internal_reference_on
    ) else $error("internal reference switched off");

endmodule

// ### drp_dac_chan.sv
// drp_dac_chan: one dac input register, latch and output switching.
// assumes writes and power enable arrive as single-cycle-valid levels.
`timescale 1ns/1ps
module drp_dac_chan
    import drp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic wr_en,
    input wire logic [DAC_W-1:0] wr_data,
    input wire logic power_en,
    input wire logic gain_sel,
    output logic [DAC_W-1:0] code,
    output logic [DAC_W-1:0] input_value,
    output logic buffer_on,
    output logic ground_switch,
    output logic gain_two
);

    logic [DAC_W-1:0] input_reg;
    logic [DAC_W-1:0] latch_reg;

    // writes are always stored, even while the buffer is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_reg <= DAC_RST; // R4
        end else if (soft_reset) begin
            input_reg <= DAC_RST; // R4
        end else if (wr_en) begin
            input_reg <= wr_data; // R10
        end
    end

    // latch frozen while powered down; catches up on the first powered edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= DAC_RST; // R4
        end else if (soft_reset) begin
            latch_reg <= DAC_RST; // R4
        end else if (power_en) begin
            latch_reg <= input_reg; // R11
        end
    end

    assign code = latch_reg;
    assign input_value = input_reg;
    assign gain_two = gain_sel; // R1
    assign buffer_on = power_en; // R16
    assign ground_switch = ~power_en; // R7

    ////////////////////////////////////////////////////////////////////
    a_latch_hold_pd: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        (!power_en && !soft_reset) |=> $stable(latch_reg)
    ) else $error("dac latch changed while powered down");

    a_latch_wake: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        (power_en && !soft_reset) |=> (latch_reg == $past(input_reg))
    ) else $error("dac latch missed its preset on wake-up");

endmodule

// ### drp_host_model.sv
// drp_host_model: apb master standing in for the host controller.
// assumes the bench calls xfer and cuts a hang with its own watchdog.
`timescale 1ns/1ps
module drp_host_model
    import drp_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one transfer; begins after an edge so back-to-back calls never
    // assign the same signal twice in one time step
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] rdata,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : ~pwdata;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values cannot pass for valid ones
        paddr <= ~a;
        pwdata <= ~pwdata;
    endtask
endmodule

// ### testbench.sv
// testbench: drp_ctrl against a register model kept in integers.
// assumes drp_pkg and drp_host_model are compiled first.
`timescale 1ns/1ps
module testbench
    import drp_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic convert_pin, external_dac_load, adc_start, adc_results_clear;
    logic [NUM_DAC-1:0][DAC_W-1:0] dac_code;
    drp_analog_t analog;
    int num_errors, samples_checked, starts, clrs, exp_starts, exp_clrs;
    int m_cfg, m_pwr, m_keep, m_clr;
    int m_in[NUM_DAC];
    int m_lat[NUM_DAC];
    integer seed;

    ////////////////////////////////////////////////////////////////////////
    drp_ctrl drp_ctrl_i(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convert_pin(convert_pin), .external_dac_load(external_dac_load),
        .adc_start(adc_start), .adc_results_clear(adc_results_clear),
        .dac_code(dac_code), .analog(analog));

    drp_host_model drp_host_model_i(.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    always @(posedge pclk) begin
        if (adc_start === 1'b1) starts++;
        if (adc_results_clear === 1'b1) clrs++;
    end

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task model_clear();
        m_cfg = 0;
        m_pwr = 0;
        m_in = '{default: 0};
        m_lat = '{default: 0};
    endtask

    function logic is_bad(input logic [7:0] a);
        return a[1:0] != 2'b00 || a > OFF_DAC_LAST;
    endfunction

    function logic [31:0] expect_rd(input logic [7:0] a);
        if (is_bad(a) || a == OFF_CONTROL) return 32'h0;
        if (a == OFF_CONFIG) return m_cfg;
        if (a == OFF_POWER) return m_pwr;
        if (a == OFF_STATUS)
            return {27'h0, m_clr[0], m_keep[0], m_cfg[CFG_LVL_BIT],
                !m_cfg[CFG_SRC_BIT], m_pwr[0]};
        return m_lat[(a - OFF_DAC_BASE) >> 2];
    endfunction

    function drp_analog_t exp_an();
        drp_analog_t x;
        x.dac_gain_two = m_cfg[7:0];
        x.dac_buffer_on = m_pwr[8:1];
        x.dac_ground_switch = ~m_pwr[8:1];
        x.reference_pin_connect = !m_cfg[CFG_SRC_BIT];
        x.reference_level_high = m_cfg[CFG_LVL_BIT];
        x.internal_reference_on = 1'b1;
        x.oscillator_on = 1'b1;
        x.adc_power_on = m_pwr[PWR_ADC_BIT];
        x.current_source_amp_on = m_pwr[PWR_CS_BIT];
        x.reference_buffer_on = m_pwr[PWR_REFBUF_BIT];
        return x;
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        drp_host_model_i.xfer(1'b1, a, d, r, e);
        check({31'h0, e}, {31'h0, is_bad(a)});
        if (a == OFF_CONFIG) m_cfg = d[CFG_W-1:0];
        if (a == OFF_POWER) begin
            if (m_pwr[0] && !d[0] && !m_cfg[CFG_DIRECT_BIT]) exp_clrs++;
            // retention flags follow the mode at the last adc power-down
            if (m_pwr[0] && !d[0]) begin
                m_keep = m_cfg[CFG_DIRECT_BIT];
                m_clr = !m_cfg[CFG_DIRECT_BIT];
            end
            m_pwr = d[PWR_W-1:0];
        end
        if (a == OFF_CONTROL && d[0] && m_pwr[0]) exp_starts++;
        if (a == OFF_CONTROL && d[1]) model_clear();
        if (a >= OFF_DAC_BASE && !is_bad(a))
            m_in[(a - OFF_DAC_BASE) >> 2] = d[DAC_W-1:0];
        // a powered latch follows its input; an unpowered one holds
        for (int n = 0; n < NUM_DAC; n++)
            if (m_pwr[n+1]) m_lat[n] = m_in[n];
    endtask

    task rd(input logic [7:0] a);
        logic [31:0] r;
        logic e;
        drp_host_model_i.xfer(1'b0, a, 32'h0, r, e);
        check(r, expect_rd(a));
        check({31'h0, e}, {31'h0, is_bad(a)});
    endtask

    task idle(input int n);
        repeat (n) begin
            @(posedge pclk);
            rnd = $random(seed);
            external_dac_load <= rnd[0];
        end
    endtask

    task chk_out();
        idle(2);
        // look clear of the edge so launched values have settled
        #1;
        check({1'b0, analog}, {1'b0, exp_an()});
        for (int n = 0; n < NUM_DAC; n++)
            check({20'h0, dac_code[n]}, m_lat[n]);
    endtask

    task read_all();
        for (int a = 0; a <= 'h30; a += 4) rd(a[7:0]);
    endtask

    task conv();
        @(posedge pclk);
        convert_pin <= 1'b1;
        if (m_pwr[0]) exp_starts++;
        idle(3);
        convert_pin <= 1'b0;
    endtask

    task end_of_test();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end

    initial begin
        seed = 32'h44f1c15f;
        presetn = 1'b0;
        convert_pin = 1'b0;
        external_dac_load = 1'b0;
        model_clear();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_out();
        read_all();
        // every source and level pairing, random gains and upper bits
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            wr(OFF_CONFIG, {rnd[31:10], i[1:0], rnd[7:0]});
            rd(OFF_CONFIG);
            rd(OFF_STATUS);
            chk_out();
        end
        wr(OFF_POWER, 32'h0);
        for (int n = 0; n < NUM_DAC; n++)
            wr(OFF_DAC_BASE + 8'(4 * n), $random(seed));
        chk_out();
        for (int n = 0; n < NUM_DAC; n++) begin
            wr(OFF_POWER, 32'h2 << n);
            chk_out();
            rd(OFF_DAC_BASE + 8'(4 * n));
        end
        for (int i = 0; i < 6; i++) begin
            wr(OFF_POWER, $random(seed));
            wr(OFF_DAC_BASE + 8'(4 * (i % NUM_DAC)), $random(seed));
            chk_out();
            rd(OFF_POWER);
        end
        // convert requests are dropped while the adc is down
        wr(OFF_POWER, 32'h0);
        conv();
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_POWER, 32'h1);
        conv();
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONFIG, 32'h400);
        wr(OFF_POWER, 32'h0);
        wr(OFF_POWER, 32'h1);
        wr(OFF_CONFIG, 32'h0);
        wr(OFF_POWER, 32'h0);
        rd(OFF_CONFIG);
        idle(2);
        check(starts, exp_starts);
        check(clrs, exp_clrs);
        wr(8'h30, 32'hffffffff);
        wr(8'h02, 32'hffffffff);
        wr(OFF_STATUS, 32'h1f);
        rd(8'h02);
        read_all();
        wr(OFF_CONFIG, 32'h7ff);
        wr(OFF_POWER, 32'h7fe);
        wr(OFF_CONTROL, 32'h2);
        idle(2);
        read_all();
        chk_out();
        wr(OFF_CONFIG, 32'h3ff);
        wr(OFF_POWER, 32'h7fe);
        @(posedge pclk);
        presetn <= 1'b0;
        idle(2);
        model_clear();
        // only a hard reset clears the retention flags
        m_keep = 0;
        m_clr = 0;
        check({1'b0, analog}, {1'b0, exp_an()});
        presetn <= 1'b1;
        chk_out();
        read_all();
        check(clrs, exp_clrs);
        end_of_test();
    end
endmodule
